// [hw/twsm_slave_match.v]
`timescale 1ns/1ps
`include "twsm_map.vh"
module twsm_slave_match (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe_n,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n
);
   // ****************************************************************
   // Line sampling and bus conditions
   // ****************************************************************
   wire scl_s;
   wire sda_s;
   reg scl_d;
   reg sda_d;
   twsm_sync u_scl (.hclk(hclk), .hresetn(hresetn), .d(scl_in), .q(scl_s));
   twsm_sync u_sda (.hclk(hclk), .hresetn(hresetn), .d(sda_in), .q(sda_s));
   // Both lines are seen two cycles late, so every condition below is
   // taken from the synchronised level and its previous value.
   // A Start is SDA falling while SCL stays high; a Stop is SDA rising.
   wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [7:0] own_slave_id_first;
   reg [7:0] own_slave_id_second;
   reg enable;
   reg start_req;
   reg clock_toggle_bit;
   reg ack_value;
   reg bus_busy_flag;
   reg addr_match;
   reg master_flag;
   reg addr_busy;
   reg [7:0] idle_cnt;
   reg bus_idle;

   // ****************************************************************
   // Register bus interface
   // ****************************************************************
   // The slave never inserts wait states and always answers OKAY.
   // Read data are taken at the address phase and stand in the data phase.
   // Writes are held over to the data phase, where the write data stand.
   reg wr_pend;
   reg [11:0] wr_addr;
   wire take = hsel & hready & htrans[1];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= take & hwrite;
         if (take) begin
            wr_addr <= haddr[11:0];
         end
         hrdata <= 32'h00000000;
         if (take & ~hwrite) begin
            case (haddr[11:0])
               `TWSM_OFF_ID1: hrdata <= {24'h000000, own_slave_id_first};
               `TWSM_OFF_ID2: hrdata <= {24'h000000, own_slave_id_second};
               `TWSM_OFF_CTL: hrdata <= {28'h0000000, ack_value, clock_toggle_bit,
                                         start_req, enable};
               `TWSM_OFF_STAT: hrdata <= {26'h0000000, addr_busy, bus_idle, master_flag,
                                          sda_s, addr_match, bus_busy_flag};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   wire wr_id1 = wr_pend & (wr_addr == `TWSM_OFF_ID1);
   wire wr_id2 = wr_pend & (wr_addr == `TWSM_OFF_ID2);
   wire wr_ctl = wr_pend & (wr_addr == `TWSM_OFF_CTL);
   wire wr_st = wr_pend & (wr_addr == `TWSM_OFF_STAT);

   // ****************************************************************
   // Own address registers
   // ****************************************************************
   // The reset value is a plain zero, which keeps both matches disabled
   // until software has written a valid address.
   // own ids
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         own_slave_id_first <= `TWSM_ID_RESET;
         own_slave_id_second <= `TWSM_ID_RESET;
      end else begin
         if (wr_id1) begin
            own_slave_id_first <= hwdata[7:0];
         end
         if (wr_id2) begin
            own_slave_id_second <= hwdata[7:0];
         end
      end
   end

   // ****************************************************************
   // Slave address receive
   // ****************************************************************
   localparam S_IDLE = 3'd0;
   localparam S_ADDR = 3'd1;
   localparam S_ACK = 3'd2;
   localparam S_ACKEND = 3'd3;
   localparam S_DATA = 3'd4;
   reg [2:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   // After eight rising edges the first address bit sits in bit 7 and the
   // direction bit in bit 0, so the address is the upper seven bits.
   // compare
   wire [6:0] rx7 = shift[7:1];
   wire hit1 = own_slave_id_first[`TWSM_ID_EN_BIT] & (own_slave_id_first[6:0] == rx7);
   wire hit2 = own_slave_id_second[`TWSM_ID_EN_BIT] & (own_slave_id_second[6:0] == rx7);

   // ****************************************************************
   // Recovery toggle and start generation
   // ****************************************************************
   // The start machine drives SDA low first and SCL low a counted time
   // later, so the Start is seen by every other device on the bus.
   localparam M_IDLE = 2'd0;
   localparam M_HOLD = 2'd1;
   localparam M_DONE = 2'd2;
   reg [1:0] mstate;
   reg [7:0] tcnt;
   reg toggling;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         enable <= 1'b0;
         start_req <= 1'b0;
         clock_toggle_bit <= 1'b0;
         ack_value <= 1'b0;
         bus_busy_flag <= 1'b0;
         addr_match <= 1'b0;
         master_flag <= 1'b0;
         addr_busy <= 1'b0;
         idle_cnt <= 8'h00;
         bus_idle <= 1'b0;
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         mstate <= M_IDLE;
         tcnt <= 8'h00;
         toggling <= 1'b0;
         scl_out <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         if (wr_ctl) begin
            enable <= hwdata[`TWSM_CTL_ENABLE_BIT];
         end
         if (!enable) begin
            start_req <= 1'b0;
            clock_toggle_bit <= 1'b0;
            ack_value <= 1'b0;
            bus_busy_flag <= 1'b0;
            addr_match <= 1'b0;
            master_flag <= 1'b0;
            addr_busy <= 1'b0;
            idle_cnt <= 8'h00;
            bus_idle <= 1'b0;
            state <= S_IDLE;
            mstate <= M_IDLE;
            toggling <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
         end else begin
            // Start and acknowledge value are set by software; start is cleared only
            // by the hardware or by disabling, the acknowledge value only by disabling.
            if (wr_ctl & hwdata[`TWSM_CTL_START_BIT]) begin
               start_req <= 1'b1;
            end
            if (wr_ctl & hwdata[`TWSM_CTL_ACK_BIT]) begin
               ack_value <= 1'b1;
            end
            if (wr_ctl & hwdata[`TWSM_CTL_TOGGLE_BIT] & ~sda_s & ~toggling) begin
               clock_toggle_bit <= 1'b1;
               toggling <= 1'b1;
               tcnt <= `TWSM_HALF_SCL;
               scl_oe_n <= 1'b1;
            end else if (toggling) begin
               if (tcnt == 8'h00) begin
                  toggling <= 1'b0;
                  clock_toggle_bit <= 1'b0;
               end else begin
                  tcnt <= tcnt - 8'h01;
               end
            end
            // Bus busy tracking; start wins over a software clear.
            if (start_cond) begin
               bus_busy_flag <= 1'b1;
            end else if (stop_cond) begin
               bus_busy_flag <= 1'b0;
            end else if (wr_st & hwdata[`TWSM_ST_BUSY_BIT]) begin
               bus_busy_flag <= 1'b0;
            end
            // Any line movement restarts the count, so the idle bit means that
            // the bus has stayed still for the whole period while busy.
            // idle observation
            if (!bus_busy_flag | scl_rise | scl_fall | (sda_s != sda_d)) begin
               idle_cnt <= 8'h00;
               bus_idle <= 1'b0;
            end else if (idle_cnt == `TWSM_IDLE_CYCLES) begin
               bus_idle <= 1'b1;
            end else begin
               idle_cnt <= idle_cnt + 8'h01;
            end
            // pending start executes when bus free
            case (mstate)
               M_IDLE: begin
                  if (start_req & ~bus_busy_flag & scl_s & sda_s & ~toggling) begin
                     sda_out <= 1'b0;
                     sda_oe_n <= 1'b0;
                     tcnt <= `TWSM_HALF_SCL;
                     mstate <= M_HOLD;
                  end
               end
               M_HOLD: begin
                  if (tcnt == 8'h00) begin
                     scl_out <= 1'b0;
                     scl_oe_n <= 1'b0;
                     mstate <= M_DONE;
                  end else begin
                     tcnt <= tcnt - 8'h01;
                  end
               end
               M_DONE: begin
                  master_flag <= 1'b1;
                  start_req <= 1'b0;
                  bus_busy_flag <= 1'b1;
                  mstate <= M_IDLE;
               end
               default: mstate <= M_IDLE;
            endcase
            // SCL is let go whenever nothing here owns the clock line.
            if (!toggling & (mstate == M_IDLE) & ~master_flag & (state != S_ACK)
                & (state != S_ACKEND)) begin
               scl_oe_n <= 1'b1;
            end
            // ****************************************************************
            // Slave address receive state machine
            // ****************************************************************
            // Bits are shifted on SCL rising; the acknowledge is driven from
            // the eighth falling edge to the ninth.
            case (state)
               S_IDLE: begin
                  if (start_cond & ~master_flag) begin
                     addr_match <= 1'b0;
                     addr_busy <= 1'b1;
                     bit_cnt <= 4'h0;
                     state <= S_ADDR;
                  end
               end
               S_ADDR: begin
                  if (stop_cond) begin
                     addr_match <= 1'b0;
                     addr_busy <= 1'b0;
                     state <= S_IDLE;
                  end else if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall & (bit_cnt == 4'h8)) begin
                     if (hit1 | hit2) begin
                        addr_match <= 1'b1;
                        sda_out <= 1'b0;
                        sda_oe_n <= 1'b0;
                        state <= S_ACK;
                     end else begin
                        addr_busy <= 1'b0;
                        state <= S_DATA;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n <= 1'b1;
                     addr_busy <= 1'b0;
                     state <= S_DATA;
                  end
               end
               S_DATA: begin
                  if (stop_cond) begin
                     addr_match <= 1'b0;
                     state <= S_IDLE;
                  end else if (start_cond) begin
                     addr_match <= 1'b0;
                     addr_busy <= 1'b1;
                     bit_cnt <= 4'h0;
                     state <= S_ADDR;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end
endmodule // twsm_slave_match

// [hw/twsm_map.vh]
`ifndef TWSM_MAP_VH
`define TWSM_MAP_VH
`define TWSM_OFF_ID1 12'h000
`define TWSM_OFF_ID2 12'h004
`define TWSM_OFF_CTL 12'h008
`define TWSM_OFF_STAT 12'h00C
`define TWSM_ID_EN_BIT 7
`define TWSM_CTL_ENABLE_BIT 0
`define TWSM_CTL_START_BIT 1
`define TWSM_CTL_TOGGLE_BIT 2
`define TWSM_CTL_ACK_BIT 3
`define TWSM_ST_BUSY_BIT 0
`define TWSM_ST_MATCH_BIT 1
`define TWSM_ST_SDA_BIT 2
`define TWSM_ST_MASTER_BIT 3
`define TWSM_ST_IDLE_BIT 4
`define TWSM_ST_ADDRBUSY_BIT 5
`define TWSM_ID_RESET 8'h00
`define TWSM_IDLE_CYCLES 8'h40
`define TWSM_HALF_SCL 8'h0A
`endif

// [hw/twsm_sync.v]
`timescale 1ns/1ps
// Two-stage synchroniser for the open-drain line inputs.
module twsm_sync (
   input wire hclk,
   input wire hresetn,
   input wire d,
   output reg q
);
   reg s1;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1 <= 1'b1;
         q <= 1'b1;
      end else begin
         s1 <= d;
         q <= s1;
      end
   end
endmodule // twsm_sync

// [testbench/twsm_monitor.sv]
`timescale 1ns/1ps
`include "twsm_map.vh"
module twsm_monitor (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe_n,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_n
);
   // ********
   // Enable tracker and SDA stability count.
   // ********
   logic ctl_ph;
   logic en_q;
   logic sda_q;
   logic [3:0] sda_stab;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_ph <= 1'b0;
         en_q <= 1'b0;
         sda_q <= 1'b1;
         sda_stab <= 4'h0;
      end else begin
         ctl_ph <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == `TWSM_OFF_CTL;
         if (ctl_ph)
            en_q <= hwdata[`TWSM_CTL_ENABLE_BIT];
         sda_q <= sda_in;
         if (sda_in != sda_q)
            sda_stab <= 4'h0;
         else if (sda_stab != 4'hF)
            sda_stab <= sda_stab + 4'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence st_rd_s;
      hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `TWSM_OFF_STAT;
   endsequence
   ready_high_a: assert property (hreadyout)
      else $error("ready went low");
   resp_okay_a: assert property (!hresp)
      else $error("error response seen");
   rst_idle_a: assert property ($rose(hresetn) |-> scl_oe_n && sda_oe_n && hrdata == 32'h0)
      else $error("outputs not idle after reset");
   sda_low_a: assert property (!sda_oe_n |-> !sda_out)
      else $error("data line driven high");
   scl_low_a: assert property (!scl_oe_n |-> !scl_out)
      else $error("clock line driven high");
   off_quiet_a: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) |-> scl_oe_n && sda_oe_n)
      else $error("lines driven while disabled");
   off_status_a: assert property (st_rd_s ##1 !en_q |-> (hrdata[3:0] & 4'hB) == 4'h0)
      else $error("status not clear while disabled");
   sda_sample_a: assert property (st_rd_s ##1 sda_stab > 4'h5 |-> hrdata[2] == sda_in)
      else $error("data sample bit wrong");
endmodule // twsm_monitor
bind twsm_slave_match twsm_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n));

// [testbench/twsm_peer.sv]
`timescale 1ns/1ps
// ********
// Remote master on the two-wire bus.
// ********
module twsm_peer (
   input wire hclk,
   input wire scl,
   input wire sda,
   output logic scl_drv,
   output logic sda_drv
);
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   task hp;
      repeat (8) @(posedge hclk);
   endtask
   task hold_sda(input logic v);
      sda_drv <= v;
   endtask
   // no data bytes follow the address, so no write or read-end step.
   task start_addr(input logic [7:0] b, output logic ack);
      logic [8:0] f;
      f = {b, 1'b1};
      sda_drv <= 1'b0;
      hp();
      scl_drv <= 1'b0;
      hp();
      for (int i = 8; i >= 0; i--) begin
         sda_drv <= f[i];
         hp();
         scl_drv <= 1'b1;
         hp();
         if (i == 0)
            ack = !sda;
         scl_drv <= 1'b0;
         hp();
      end
   endtask
   task stop_cond;
      sda_drv <= 1'b0;
      hp();
      scl_drv <= 1'b1;
      hp();
      sda_drv <= 1'b1;
      hp();
   endtask
endmodule // twsm_peer

// [testbench/twsm_slave_match_tb_top.sv]
`timescale 1ns/1ps
`include "twsm_map.vh"
module twsm_slave_match_tb_top;
   logic hclk, hresetn, hsel, hwrite, ack, e;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, q, v;
   logic [6:0] a1, a2, t;
   logic [7:0] i1, i2;
   integer k, miscompares, n_tests, cyc;
   wire [31:0] hrdata;
   wire hreadyout, hresp, scl_out, scl_oe_n, sda_out, sda_oe_n, p_scl, p_sda;
   wire hready = hreadyout;
   wire scl = p_scl & (scl_oe_n | scl_out);
   wire sda = p_sda & (sda_oe_n | sda_out);
   localparam logic [31:0] ID1 = {20'h0, `TWSM_OFF_ID1};
   localparam logic [31:0] CTL = {20'h0, `TWSM_OFF_CTL};
   localparam logic [31:0] ST = {20'h0, `TWSM_OFF_STAT};
   twsm_slave_match u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(scl_out),
      .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
   twsm_peer u_peer (.hclk(hclk), .scl(scl), .sda(sda), .scl_drv(p_scl), .sda_drv(p_sda));
   // ********
   // Checking and bus tasks.
   // ********
   function automatic logic hit(input logic [7:0] id, input logic [6:0] a);
      return id[`TWSM_ID_EN_BIT] && id[6:0] == a;
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_tests = n_tests + 1;
      if (s !== x) begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: saw %h want %h", $time, s, x);
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task end_of_test;
      $display("checks %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      {miscompares, n_tests, cyc} = '0;
      k = $urandom(32'h7d0407ca);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, 32'h10, 32'h0);
      chk(q, 32'h0);
      for (k = 0; k < 4; k++) begin
         v = $urandom;
         xfer(1'b1, ID1 + 4 * (k % 2), v);
         xfer(1'b0, ID1 + 4 * (k % 2), 32'h0);
         chk(q[7:0], v[7:0]);
      end
      xfer(1'b0, ST, 32'h0);
      chk(q[1:0], 2'b00);
      a1 = $urandom;
      a2 = a1 ^ 7'h2A;
      i2 = {1'b1, a2};
      xfer(1'b1, CTL, 32'h1);
      xfer(1'b1, ID1 + 4, {24'h0, i2});
      for (k = 0; k < 6; k++) begin
         i1 = {k != 2, a1};
         t = k == 1 ? a2 : k == 3 ? a1 ^ 7'h01 : k == 4 ? a1 ^ 7'h40 : k == 5 ? 7'($urandom) : a1;
         e = hit(i1, t) | hit(i2, t);
         xfer(1'b1, ID1, {24'h0, i1});
         u_peer.start_addr({t, 1'b0}, ack);
         chk(ack, e);
         xfer(1'b0, ST, 32'h0);
         chk(q[4:0], {3'b001, e, 1'b1});
         if (k == 0) begin
            repeat (80) @(posedge hclk);
            xfer(1'b0, ST, 32'h0);
            chk(q[4], 1'b1);
            xfer(1'b1, CTL, 32'h0);
            repeat (2) @(posedge hclk);
            xfer(1'b0, ST, 32'h0);
            chk({q[3], q[1:0]}, 3'b000);
            xfer(1'b1, CTL, 32'h1);
         end
         u_peer.stop_cond();
         repeat (20) @(posedge hclk);
      end
      u_peer.hold_sda(1'b0);
      xfer(1'b1, CTL, 32'h3);
      xfer(1'b0, ST, 32'h0);
      chk(q[2], 1'b0);
      chk(q[3], 1'b0);
      xfer(1'b1, CTL, 32'h5);
      repeat (30) @(posedge hclk);
      xfer(1'b0, CTL, 32'h0);
      chk(q[2], 1'b0);
      xfer(1'b1, CTL, 32'h0);
      xfer(1'b1, CTL, 32'h1);
      u_peer.hold_sda(1'b1);
      repeat (6) @(posedge hclk);
      xfer(1'b0, ST, 32'h0);
      chk(q[2], 1'b1);
      xfer(1'b1, CTL, 32'h3);
      xfer(1'b1, ST, 32'h1);
      q = 32'h0;
      for (k = 0; k < 30 && q[3] !== 1'b1; k++)
         xfer(1'b0, ST, 32'h0);
      chk(q[3], 1'b1);
      end_of_test();
   end
endmodule // twsm_slave_match_tb_top
